// ===== src/drw_monitor.sv
// Reference trim, current cap, warning monitor and frequency bypass
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1 - While catch-up is asserted the remote reference is raised by the trim percentage of itself.
// R2 - While slow-down is asserted the remote reference is lowered by the same trim percentage.
// R3 - Output current is capped at a percentage of rated drive current, default 160 percent.
// R4 - A low-current warning is raised while output current is below its low threshold, default 0 A.
// R5 - A high-current warning is raised while output current is above its high threshold, default full scale.
// R6 - A low-frequency warning is raised while output frequency is below its low threshold, default 0 Hz.
// R7 - A high-frequency warning is raised while output frequency is above its high threshold, default 132 Hz.
// R8 - The high-frequency threshold is bounded between the low one and 132 Hz or 1000 Hz per range.
// R9 - A low-feedback warning is raised while feedback is below its low threshold, default -4000.
// R10 - A high-feedback warning is raised while feedback is above its high threshold, default 4000.
// R11 - All six warnings are held off during ramp-up after start, after stop and while stopped.
// R12 - Warning comparisons start only once output frequency has reached the resulting reference.
// R13 - Any warning can be routed to the digital signal output and to the relay output.
// R14 - Frequencies inside a band of width 0 to 100 Hz around each bypass centre are avoided, zero width disables.
// R15 - Two bypass centres are programmable from 0 to 1000 Hz with default zero.
// R16 - A reference inside a bypass band is moved to the nearer band edge.
// R17 - Each warning clears the cycle after its condition ends or when warnings become suppressed.
module drw_monitor
  import drw_pkg::*;
(
  input wire logic pclk,                 // APB clock, 25 MHz
  input wire logic presetn,              // Async reset, active low
  input wire logic psel,                 // APB select
  input wire logic penable,              // APB enable
  input wire logic pwrite,               // APB direction
  input wire logic [7:0] paddr,          // APB byte address
  input wire logic [31:0] pwdata,        // APB write data
  output logic [31:0] prdata,            // APB read data
  output logic pready,                   // APB ready
  output logic pslverr,                  // APB error, unmapped
  input wire logic catch_up_in,          // Catch-up digital input pin
  input wire logic slow_down_in,         // Slow-down digital input pin
  input wire logic run_in,               // Start command pin, high = run
  input wire logic [15:0] remote_ref,    // Remote reference, 0.1 Hz
  input wire logic [15:0] out_freq,      // Output frequency, 0.1 Hz
  input wire logic [15:0] out_current,   // Output current, 0.1 A
  input wire logic [31:0] feedback,      // Process feedback, signed
  output logic [15:0] freq_ref,          // Trimmed, bypassed reference
  output logic [15:0] output_current_cap, // Current cap, 0.1 A
  output logic cap_active,               // Current at or above cap
  output logic [5:0] warn,               // Live warning flags
  output logic warn_dout,                // Digital signal output
  output logic warn_relay,               // Relay output
  output logic irq                       // Level interrupt
);

  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic range_hi;
  logic [15:0] trim_pct;
  logic [15:0] cap_pct;
  logic [15:0] rated_drive_current;
  logic [15:0] current_low_threshold;
  logic [15:0] current_high_threshold;
  logic [15:0] freq_low_threshold;
  logic [15:0] freq_high_threshold;
  logic [31:0] feedback_low_threshold;
  logic [31:0] feedback_high_threshold;
  logic [15:0] byp_bw;
  logic [15:0] byp1;
  logic [15:0] byp2;
  logic [5:0] route_dout;
  logic [5:0] route_relay;
  logic [6:0] status;
  logic [6:0] mask;
  logic armed;

  // Saturate an unsigned value to a 16-bit limit
  function automatic logic [15:0] sat16(input logic [31:0] v,
                                        input logic [15:0] lim);
    sat16 = (v > {16'h0000, lim}) ? lim : v[15:0];
  endfunction

  // Move a reference lying inside one band to the nearer edge
  function automatic logic [15:0] bypass(input logic [15:0] f,
                                         input logic [15:0] centre,
                                         input logic [15:0] bw);
    logic [16:0] half;
    logic [16:0] lo;
    logic [16:0] hi;
    half = {2'b00, bw[15:1]};
    lo = ({1'b0, centre} > half) ? {1'b0, centre} - half : 17'h00000;
    hi = {1'b0, centre} + half;
    if (bw == 16'h0000 || {1'b0, f} <= lo || {1'b0, f} >= hi)
      bypass = f;
    else if (f < centre)
      bypass = lo[15:0];
    else
      bypass = sat16({15'h0000, hi}, 16'hffff);
  endfunction

  // Input pins from outside the clock domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end
    else
    begin
      pin_s1 <= {run_in, slow_down_in, catch_up_in};
      pin_s2 <= pin_s1;
    end
  end

  wire catch_up = pin_s2[0];
  wire slow_down = pin_s2[1];
  wire run = pin_s2[2];

  // Reference trim; both inputs together cancel out
  wire [31:0] trim_prod = {16'h0000, remote_ref} * {16'h0000, trim_pct};
  wire [15:0] trim_delta = 16'(trim_prod / DRW_TRIM_SCALE);
  wire [16:0] ref_up = {1'b0, remote_ref} + {1'b0, trim_delta};
  wire [15:0] ref_raised = ref_up[16] ? 16'hffff : ref_up[15:0]; // R1
  wire [15:0] ref_lowered = remote_ref - trim_delta;             // R2
  wire [15:0] ref_trim = (catch_up && !slow_down) ? ref_raised :
                         (slow_down && !catch_up) ? ref_lowered :
                         remote_ref;
  wire [15:0] ref_byp1 = bypass(ref_trim, byp1, byp_bw);    // R14 R16
  wire [15:0] next_freq_ref = bypass(ref_byp1, byp2, byp_bw); // R14 R16

  // Current cap from rated current
  wire [31:0] cap_prod = {16'h0000, rated_drive_current} *
                         {16'h0000, cap_pct};
  wire [15:0] next_cap = sat16(cap_prod / DRW_CAP_SCALE, 16'hffff); // R3

  // High-frequency threshold kept inside its legal window
  wire [15:0] fmax = range_hi ? DRW_FMAX_HIGH_RANGE : DRW_FMAX_LOW_RANGE;
  wire [15:0] freq_high_threshold_cap = sat16({16'h0000, freq_high_threshold}, fmax);
  wire [15:0] freq_high_threshold_eff = (freq_high_threshold_cap < freq_low_threshold) ?
                          freq_low_threshold : freq_high_threshold_cap;   // R8

  // Comparisons
  wire [5:0] cond;
  assign cond[DRW_W_CUR_LOW] = out_current < current_low_threshold;   // R4
  assign cond[DRW_W_CUR_HIGH] = out_current > current_high_threshold; // R5
  assign cond[DRW_W_FREQ_LOW] = out_freq < freq_low_threshold;        // R6
  assign cond[DRW_W_FREQ_HIGH] = out_freq > freq_high_threshold_eff;                // R7
  assign cond[DRW_W_FB_LOW] =
    $signed(feedback) < $signed(feedback_low_threshold);              // R9
  assign cond[DRW_W_FB_HIGH] =
    $signed(feedback) > $signed(feedback_high_threshold);             // R10

  // Arm only once running and at reference; stop disarms at once
  wire next_armed = run && (armed || out_freq == freq_ref); // R11 R12
  wire [5:0] next_warn = armed ? cond : 6'h00;              // R11 R17
  wire next_cap_active = out_current >= output_current_cap; // R3

  // Events for the sticky status
  wire [6:0] events = {next_cap_active & ~cap_active, next_warn & ~warn};

  // APB decode; one wait-free access phase
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd_status = access && !pwrite && paddr == DRW_STATUS_OFF;
  wire fb_in_range_lo = $signed(pwdata) >= -$signed(DRW_FB_LIMIT);
  wire fb_in_range_hi = $signed(pwdata) <= $signed(DRW_FB_LIMIT);
  wire [31:0] fb_wdata = !fb_in_range_lo ? -DRW_FB_LIMIT :
                         !fb_in_range_hi ? DRW_FB_LIMIT : pwdata;
  wire [15:0] w16 = pwdata[15:0];
  wire mapped = paddr[1:0] == 2'b00 && paddr <= DRW_REF_OUT_OFF;

  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      DRW_CTRL_OFF: rd_word = {31'h0, range_hi};
      DRW_TRIM_PCT_OFF: rd_word = {16'h0000, trim_pct};
      DRW_CAP_PCT_OFF: rd_word = {16'h0000, cap_pct};
      DRW_RATED_OFF: rd_word = {16'h0000, rated_drive_current};
      DRW_CUR_LOW_OFF: rd_word = {16'h0000, current_low_threshold};
      DRW_CUR_HIGH_OFF: rd_word = {16'h0000, current_high_threshold};
      DRW_FREQ_LOW_OFF: rd_word = {16'h0000, freq_low_threshold};
      DRW_FREQ_HIGH_OFF: rd_word = {16'h0000, freq_high_threshold_eff};
      DRW_FB_LOW_OFF: rd_word = feedback_low_threshold;
      DRW_FB_HIGH_OFF: rd_word = feedback_high_threshold;
      DRW_BYP_BW_OFF: rd_word = {16'h0000, byp_bw};
      DRW_BYP1_OFF: rd_word = {16'h0000, byp1};
      DRW_BYP2_OFF: rd_word = {16'h0000, byp2};
      DRW_ROUTE_OFF: rd_word = {18'h0, route_relay, 2'b00, route_dout};
      DRW_STATUS_OFF: rd_word = {25'h0, status};
      DRW_MASK_OFF: rd_word = {25'h0, mask};
      DRW_LIVE_OFF: rd_word = {24'h0, cap_active, armed, warn};
      DRW_REF_OUT_OFF: rd_word = {16'h0000, freq_ref};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Read data captured in setup so it is stable over the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= rd_word;
  end

  // Configuration registers; trim, high-frequency, feedback and bypass values clamped to their legal ranges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      range_hi <= 1'b0;
      trim_pct <= DRW_TRIM_PCT_RST;
      cap_pct <= DRW_CAP_PCT_RST;
      rated_drive_current <= DRW_RATED_RST;
      current_low_threshold <= DRW_CUR_LOW_RST;
      current_high_threshold <= DRW_CUR_HIGH_RST;
      freq_low_threshold <= DRW_FREQ_LOW_RST;
      freq_high_threshold <= DRW_FREQ_HIGH_RST;
      feedback_low_threshold <= DRW_FB_LOW_RST;
      feedback_high_threshold <= DRW_FB_HIGH_RST;
      byp_bw <= DRW_BYP_RST;
      byp1 <= DRW_BYP_RST;
      byp2 <= DRW_BYP_RST;
      route_dout <= 6'h00;
      route_relay <= 6'h00;
      mask <= 7'h00;
    end
    else if (wr)
    begin
      unique case (paddr)
        DRW_CTRL_OFF: range_hi <= pwdata[DRW_CTRL_RANGE_BIT];
        DRW_TRIM_PCT_OFF: trim_pct <= sat16(pwdata, DRW_TRIM_MAX);
        DRW_CAP_PCT_OFF: cap_pct <= w16;
        DRW_RATED_OFF: rated_drive_current <= w16;
        DRW_CUR_LOW_OFF: current_low_threshold <= w16;
        DRW_CUR_HIGH_OFF: current_high_threshold <= w16;
        DRW_FREQ_LOW_OFF: freq_low_threshold <= w16;
        DRW_FREQ_HIGH_OFF:
          freq_high_threshold <= sat16(pwdata, DRW_FMAX_HIGH_RANGE); // R8
        DRW_FB_LOW_OFF: feedback_low_threshold <= fb_wdata;
        DRW_FB_HIGH_OFF: feedback_high_threshold <= fb_wdata;
        DRW_BYP_BW_OFF: byp_bw <= sat16(pwdata, DRW_BW_MAX);       // R14
        DRW_BYP1_OFF: byp1 <= sat16(pwdata, DRW_FMAX_HIGH_RANGE);  // R15
        DRW_BYP2_OFF: byp2 <= sat16(pwdata, DRW_FMAX_HIGH_RANGE);  // R15
        DRW_ROUTE_OFF:
        begin
          route_dout <= pwdata[DRW_ROUTE_DOUT_LSB +: 6];
          route_relay <= pwdata[DRW_ROUTE_RELAY_LSB +: 6];
        end
        DRW_MASK_OFF: mask <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // Status: a read clears only the bits it reported (held in prdata
  // since setup), so an event landing at the setup edge is not lost
  wire [6:0] next_status = (rd_status ? status & ~prdata[6:0] : status) |
                           events;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= 7'h00;
      armed <= 1'b0;
      warn <= 6'h00;
      cap_active <= 1'b0;
      freq_ref <= 16'h0000;
      // Full scale until computed: no false cap event after reset
      output_current_cap <= 16'hffff;
    end
    else
    begin
      status <= next_status;
      armed <= next_armed;             // R12
      warn <= next_warn;               // R17
      cap_active <= next_cap_active;
      freq_ref <= next_freq_ref;       // R16
      output_current_cap <= next_cap;  // R3
    end
  end

  // Routing of warnings to the outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      warn_dout <= 1'b0;
      warn_relay <= 1'b0;
    end
    else
    begin
      warn_dout <= |(next_warn & route_dout);   // R13
      warn_relay <= |(next_warn & route_relay); // R13
    end
  end

  assign irq = |(status & mask);

endmodule
`default_nettype wire

// ===== pkg/drw_pkg.sv
// Package for the drive reference trim and warning monitor
package drw_pkg;

  // Register byte offsets
  localparam logic [7:0] DRW_CTRL_OFF = 8'h00;
  localparam logic [7:0] DRW_TRIM_PCT_OFF = 8'h04;
  localparam logic [7:0] DRW_CAP_PCT_OFF = 8'h08;
  localparam logic [7:0] DRW_RATED_OFF = 8'h0c;
  localparam logic [7:0] DRW_CUR_LOW_OFF = 8'h10;
  localparam logic [7:0] DRW_CUR_HIGH_OFF = 8'h14;
  localparam logic [7:0] DRW_FREQ_LOW_OFF = 8'h18;
  localparam logic [7:0] DRW_FREQ_HIGH_OFF = 8'h1c;
  localparam logic [7:0] DRW_FB_LOW_OFF = 8'h20;
  localparam logic [7:0] DRW_FB_HIGH_OFF = 8'h24;
  localparam logic [7:0] DRW_BYP_BW_OFF = 8'h28;
  localparam logic [7:0] DRW_BYP1_OFF = 8'h2c;
  localparam logic [7:0] DRW_BYP2_OFF = 8'h30;
  localparam logic [7:0] DRW_ROUTE_OFF = 8'h34;
  localparam logic [7:0] DRW_STATUS_OFF = 8'h38;
  localparam logic [7:0] DRW_MASK_OFF = 8'h3c;
  localparam logic [7:0] DRW_LIVE_OFF = 8'h40;
  localparam logic [7:0] DRW_REF_OUT_OFF = 8'h44;

  // Field positions
  localparam int DRW_CTRL_RANGE_BIT = 0;
  localparam int DRW_ROUTE_DOUT_LSB = 0;
  localparam int DRW_ROUTE_RELAY_LSB = 8;
  localparam int DRW_LIVE_ARMED_BIT = 6;
  localparam int DRW_LIVE_CAP_BIT = 7;
  localparam int DRW_EV_CAP_BIT = 6;
  localparam int DRW_NWARN = 6;

  // Warning bit order
  localparam int DRW_W_CUR_LOW = 0;
  localparam int DRW_W_CUR_HIGH = 1;
  localparam int DRW_W_FREQ_LOW = 2;
  localparam int DRW_W_FREQ_HIGH = 3;
  localparam int DRW_W_FB_LOW = 4;
  localparam int DRW_W_FB_HIGH = 5;

  // Scaling: frequency 0.1 Hz, current 0.1 A, trim 0.01 %,
  // cap 0.1 %, feedback 0.001 unit
  localparam logic [31:0] DRW_TRIM_SCALE = 32'h0000_2710;  // 100.00 %
  localparam logic [31:0] DRW_CAP_SCALE = 32'h0000_03e8;   // 100.0 %
  localparam logic [15:0] DRW_TRIM_MAX = 16'h2710;
  localparam logic [15:0] DRW_FMAX_LOW_RANGE = 16'h0528;   // 132.0 Hz
  localparam logic [15:0] DRW_FMAX_HIGH_RANGE = 16'h2710;  // 1000.0 Hz
  localparam logic [15:0] DRW_BW_MAX = 16'h03e8;           // 100.0 Hz
  localparam logic [31:0] DRW_FB_LIMIT = 32'h05f5_e100;    // 100000.000

  // Values after reset
  localparam logic [15:0] DRW_TRIM_PCT_RST = 16'h0000;
  localparam logic [15:0] DRW_CAP_PCT_RST = 16'h0640;      // 160.0 %
  localparam logic [15:0] DRW_RATED_RST = 16'h0064;        // arbitrary
  localparam logic [15:0] DRW_CUR_LOW_RST = 16'h0000;
  localparam logic [15:0] DRW_CUR_HIGH_RST = 16'hffff;     // full scale
  localparam logic [15:0] DRW_FREQ_LOW_RST = 16'h0000;
  localparam logic [15:0] DRW_FREQ_HIGH_RST = 16'h0528;    // 132.0 Hz
  localparam logic [31:0] DRW_FB_LOW_RST = 32'hffc2_f700;  // -4000.000
  localparam logic [31:0] DRW_FB_HIGH_RST = 32'h003d_0900; // 4000.000
  localparam logic [15:0] DRW_BYP_RST = 16'h0000;

endpackage

// ===== verification/drw_plant_model.sv
// Motor, load and feedback sensor seen by the monitor
`timescale 1ns/100ps
`default_nettype none
module drw_plant_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic run_in, // motor enabled
  input wire logic [15:0] freq_ref, // speed target
  input wire logic [15:0] cur_set, // load current
  input wire logic [31:0] fb_set, // sensor value
  output logic [15:0] out_freq, // speed
  output logic [15:0] out_current, // current
  output logic [31:0] feedback // sensor
);
  // Finite slew so arming only follows a real catch-up
  wire [15:0] target = run_in ? freq_ref : 16'h0000;
  wire up = out_freq < target;
  wire [15:0] gap = up ? target - out_freq : out_freq - target;
  wire [15:0] step = (gap > 16'h000a) ? 16'h000a : gap;
  wire [15:0] next_freq = up ? out_freq + step : out_freq - step;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      out_freq <= 16'h0000;
      out_current <= 16'h0000;
      feedback <= 32'h0000_0000;
    end
    else
    begin
      out_freq <= next_freq;
      out_current <= cur_set;
      feedback <= fb_set;
    end
endmodule
`default_nettype wire

// ===== verification/drw_monitor_asserts.sv
// Port-level assertions for the warning monitor
`timescale 1ns/100ps
`default_nettype none
module drw_monitor_asserts (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic catch_up_in, // pin
  input wire logic slow_down_in, // pin
  input wire logic run_in, // pin
  input wire logic [15:0] remote_ref, // reference
  input wire logic [15:0] out_freq, // speed
  input wire logic [15:0] out_current, // current
  input wire logic [31:0] feedback, // sensor
  input wire logic [15:0] freq_ref, // trimmed ref
  input wire logic [15:0] output_current_cap, // cap
  input wire logic cap_active, // capping
  input wire logic [5:0] warn, // flags
  input wire logic warn_dout, // dout
  input wire logic warn_relay, // relay
  input wire logic irq // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_cap_level: assert property (
    presetn && $past(presetn) |->
    cap_active == ($past(out_current) >= $past(output_current_cap)))
    else $error("cap flag does not follow current");
  chk_stop_quiet: assert property ((!run_in)[*6] |-> warn == 6'h00)
    else $error("warning while stopped");
  chk_arm_hold: assert property (
    $rose(run_in) |-> (warn == 6'h00)[*3])
    else $error("warning before reference reached");
  chk_cur_low_cause: assert property (
    warn[0] |-> $past(out_current) != 16'hffff)
    else $error("low current flag at full scale");
  chk_cur_high_cause: assert property (
    warn[1] |-> $past(out_current) != 16'h0000)
    else $error("high current flag at zero");
  chk_freq_low_cause: assert property (
    warn[2] |-> $past(out_freq) != 16'hffff)
    else $error("low frequency flag at full scale");
  chk_freq_high_cause: assert property (
    warn[3] |-> $past(out_freq) != 16'h0000)
    else $error("high frequency flag at zero");
  chk_freq_excl: assert property (!(warn[2] && warn[3]))
    else $error("both frequency flags set");
  chk_route_quiet: assert property (
    warn == 6'h00 |-> !warn_dout && !warn_relay)
    else $error("output raised with no warning");
  cover property (cap_active);
  cover property (warn[1] && warn_relay);
  cover property (irq);
endmodule
`default_nettype wire

// ===== verification/drw_monitor_test.sv
// Directed testbench for the warning monitor
`timescale 1ns/100ps
`default_nettype none
module drw_monitor_test import drw_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic catch_up_in = 0, slow_down_in = 0, run_in = 0, err;
  logic pready, pslverr, cap_active, warn_dout, warn_relay, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, fb_set = 32'h0, prdata, feedback, rd;
  logic [15:0] remote_ref = 16'h0, cur_set = 16'h0, out_freq, out_current;
  logic [15:0] freq_ref, output_current_cap;
  logic [5:0] warn;
  int err_count = 0, total_checks = 0, cyc = 0;
  logic [7:0] ra [8] = '{DRW_CAP_PCT_OFF, DRW_FREQ_HIGH_OFF, DRW_FB_LOW_OFF,
    DRW_FB_HIGH_OFF, DRW_CUR_HIGH_OFF, DRW_CUR_LOW_OFF, DRW_FREQ_LOW_OFF,
    DRW_STATUS_OFF};
  logic [31:0] re [8] = '{32'h640, 32'h528, 32'hffc2f700, 32'h3d0900,
    32'hffff, 32'h0, 32'h0, 32'h0};
  logic [1:0] tm [3] = '{2'h2, 2'h1, 2'h3};
  logic [15:0] te [3] = '{16'h44c, 16'h384, 16'h3e8};
  logic [15:0] br [4] = '{16'h3d4, 16'h3fc, 16'h7c6, 16'h3e8};
  logic [15:0] be [4] = '{16'h3b6, 16'h41a, 16'h79e, 16'h41a};
  drw_monitor u_drw_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .catch_up_in(catch_up_in), .slow_down_in(slow_down_in),
    .run_in(run_in), .remote_ref(remote_ref), .out_freq(out_freq),
    .out_current(out_current), .feedback(feedback), .freq_ref(freq_ref),
    .output_current_cap(output_current_cap), .cap_active(cap_active),
    .warn(warn), .warn_dout(warn_dout), .warn_relay(warn_relay), .irq(irq));
  drw_plant_model u_drw_plant_model (.pclk(pclk), .presetn(presetn),
    .run_in(run_in), .freq_ref(freq_ref), .cur_set(cur_set),
    .fb_set(fb_set), .out_freq(out_freq), .out_current(out_current),
    .feedback(feedback));
  initial forever #20 pclk = ~pclk;
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial
  begin
    wt(8);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(ra[i], re[i]);
    apb(1'b0, 8'h48, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    $display("reset values done");
    apb(1'b1, DRW_TRIM_PCT_OFF, 32'h3e8);
    remote_ref <= 16'h03e8;
    for (int i = 0; i < 3; i++)
    begin
      catch_up_in <= tm[i][1];
      slow_down_in <= tm[i][0];
      wt(5);
      chk(freq_ref, te[i]);
    end
    catch_up_in <= 1'b0;
    slow_down_in <= 1'b0;
    apb(1'b1, DRW_TRIM_PCT_OFF, 32'hffff);
    rdc(DRW_TRIM_PCT_OFF, 32'h2710);
    apb(1'b1, DRW_RATED_OFF, 32'hc8);
    apb(1'b1, DRW_CAP_PCT_OFF, 32'h1f4);
    cur_set <= 16'h0096;
    wt(4);
    chk(output_current_cap, 32'h64);
    chk(cap_active, 32'h1);
    cur_set <= 16'h0063;
    wt(4);
    chk(cap_active, 32'h0);
    apb(1'b1, DRW_FREQ_HIGH_OFF, 32'h1388);
    rdc(DRW_FREQ_HIGH_OFF, 32'h528);
    apb(1'b1, DRW_CTRL_OFF, 32'h1);
    rdc(DRW_FREQ_HIGH_OFF, 32'h1388);
    apb(1'b1, DRW_FREQ_LOW_OFF, 32'h1770);
    rdc(DRW_FREQ_HIGH_OFF, 32'h1770);
    apb(1'b1, DRW_FREQ_LOW_OFF, 32'h0);
    apb(1'b1, DRW_CTRL_OFF, 32'h0);
    apb(1'b1, DRW_FB_LOW_OFF, 32'h8000_0000);
    rdc(DRW_FB_LOW_OFF, 32'hfa0a_1f00);
    $display("trim cap range done");
    apb(1'b1, DRW_BYP_BW_OFF, 32'h64);
    apb(1'b1, DRW_BYP1_OFF, 32'h3e8);
    apb(1'b1, DRW_BYP2_OFF, 32'h7d0);
    for (int i = 0; i < 4; i++)
    begin
      remote_ref <= br[i];
      wt(3);
      chk(freq_ref, be[i]);
    end
    apb(1'b1, DRW_BYP_BW_OFF, 32'h0);
    remote_ref <= 16'h03d4;
    wt(3);
    chk(freq_ref, 32'h3d4);
    $display("bypass done");
    remote_ref <= 16'h03e8;
    cur_set <= 16'h0014;
    fb_set <= 32'h0000_00c8;
    apb(1'b1, DRW_CUR_LOW_OFF, 32'h32);
    apb(1'b1, DRW_CUR_HIGH_OFF, 32'h12c);
    apb(1'b1, DRW_FREQ_HIGH_OFF, 32'h384);
    apb(1'b1, DRW_FB_LOW_OFF, 32'hffffff9c);
    apb(1'b1, DRW_FB_HIGH_OFF, 32'h64);
    apb(1'b1, DRW_ROUTE_OFF, 32'h208);
    chk(warn, 32'h0);
    run_in <= 1'b1;
    wt(6);
    chk(warn, 32'h0);
    wt(120);
    chk(warn, 32'h29);
    chk(warn_dout, 32'h1);
    chk(warn_relay, 32'h0);
    chk(irq, 32'h0);
    apb(1'b1, DRW_MASK_OFF, 32'h7f);
    wt(1);
    chk(irq, 32'h1);
    cur_set <= 16'h0190;
    fb_set <= 32'hffffff38;
    apb(1'b1, DRW_FREQ_LOW_OFF, 32'h44c);
    wt(4);
    chk(warn, 32'h16);
    chk(warn_dout, 32'h0);
    chk(warn_relay, 32'h1);
    rdc(DRW_LIVE_OFF, 32'hd6);
    rdc(DRW_REF_OUT_OFF, 32'h3e8);
    rdc(DRW_STATUS_OFF, 32'h7f);
    wt(1);
    chk(irq, 32'h0);
    rdc(DRW_STATUS_OFF, 32'h0);
    cur_set <= 16'h0014;
    rdc(DRW_STATUS_OFF, 32'h0);
    rdc(DRW_STATUS_OFF, 32'h1);
    run_in <= 1'b0;
    wt(8);
    chk(warn, 32'h0);
    chk(warn_relay, 32'h0);
    $display("warnings done");
    stop_test();
  end
endmodule
bind drw_monitor drw_monitor_asserts u_drw_monitor_asserts (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .catch_up_in(catch_up_in),
  .slow_down_in(slow_down_in), .run_in(run_in), .remote_ref(remote_ref),
  .out_freq(out_freq), .out_current(out_current), .feedback(feedback),
  .freq_ref(freq_ref), .output_current_cap(output_current_cap),
  .cap_active(cap_active), .warn(warn), .warn_dout(warn_dout),
  .warn_relay(warn_relay), .irq(irq));
`default_nettype wire
